/* File: sdwo_pkg.sv */
// Purpose: Shared constants for the card host special-operations block
// Assumes: Single 40 MHz system clock; card clock made by a divider
// Notes:   Command indices and timing counts defined here; monitor and bench also use literal indices
package sdwo_pkg;
  // ----------------------------------------------------------------
  // Command indices
  // ----------------------------------------------------------------
  localparam logic [5:0] CMD_SET_BLOCK_COUNT = 6'h17;
  localparam logic [5:0] CMD_WRITE_ONE       = 6'h18;
  localparam logic [5:0] CMD_WRITE_MULTI     = 6'h19;
  localparam logic [5:0] CMD_PROGRAM_ID      = 6'h1A;
  localparam logic [5:0] CMD_PROGRAM_SPEC    = 6'h1B;
  localparam logic [5:0] CMD_SET_PROTECT     = 6'h1C;
  localparam logic [5:0] CMD_CLR_PROTECT     = 6'h1D;
  localparam logic [5:0] CMD_SEND_PROTECT    = 6'h1E;
  localparam logic [5:0] CMD_STOP            = 6'h0C;
  // ----------------------------------------------------------------
  // Response kinds
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_NONE  = 2'h0;
  localparam logic [1:0] RESP_SHORT = 2'h1;
  localparam logic [1:0] RESP_BUSY  = 2'h2;
  // ----------------------------------------------------------------
  // Bus widths, timing in card clock cycles, and the card clock divide in system clocks
  // ----------------------------------------------------------------
  localparam logic [1:0] WIDTH_1BIT       = 2'h0;
  localparam logic [1:0] WIDTH_4BIT       = 2'h1;
  localparam logic [1:0] WIDTH_8BIT       = 2'h2;
  localparam logic [3:0] RW_ASSERT_CYCLES = 4'h2;
  localparam logic [3:0] RW_STOP_CYCLES   = 4'h2;
  localparam logic [3:0] CLK_STOP_CYCLES  = 4'h2;
  localparam logic [3:0] CCS_DIS_CYCLES   = 4'h8;
  localparam logic [7:0] CARD_CLK_DIV     = 8'h4;
  // ----------------------------------------------------------------
  // Data path machine states, Gray along the read-wait path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SDWO_IDLE     = 3'b000,
    SDWO_RW_DELAY = 3'b001,
    SDWO_RW_HOLD  = 3'b011,
    SDWO_RW_STOP  = 3'b010,
    SDWO_RW_HIGH  = 3'b110,
    SDWO_RECEIVE  = 3'b111,
    SDWO_CK_STOP  = 3'b101,
    SDWO_BUSY     = 3'b100
  } sdwo_state_e;
endpackage

/* File: sdwo_cmd_check.sv */
// Purpose: Classifies a host command and forms its argument
// Assumes: Inputs from the same clock domain
// Notes:   Purely combinational lookup, registered by the caller
`timescale 1ns/100ps
`default_nettype none
module sdwo_cmd_check
(
  input  wire logic [5:0]  cmd_index,
  input  wire logic [31:0] cmd_addr,
  input  wire logic [15:0] block_count,
  output logic [31:0]      cmd_arg,
  output logic [1:0]       resp_kind,
  output logic             has_data,
  output logic             known
);
  // ----------------------------------------------------------------
  // Argument and response lookup
  // ----------------------------------------------------------------
  always_comb
  begin
    cmd_arg   = 32'h0000_0000;
    resp_kind = sdwo_pkg::RESP_SHORT;
    has_data  = 1'b0;
    known     = 1'b1;
    case (cmd_index)
      sdwo_pkg::CMD_SET_BLOCK_COUNT: cmd_arg = {16'h0000, block_count};
      sdwo_pkg::CMD_WRITE_ONE:
      begin
        cmd_arg  = cmd_addr;
        has_data = 1'b1;
      end
      sdwo_pkg::CMD_WRITE_MULTI:
      begin
        cmd_arg  = cmd_addr;
        has_data = 1'b1;
      end
      sdwo_pkg::CMD_PROGRAM_ID:   has_data = 1'b1;
      sdwo_pkg::CMD_PROGRAM_SPEC: has_data = 1'b1;
      sdwo_pkg::CMD_SET_PROTECT:
      begin
        cmd_arg   = cmd_addr;
        resp_kind = sdwo_pkg::RESP_BUSY;
      end
      sdwo_pkg::CMD_CLR_PROTECT:
      begin
        cmd_arg   = cmd_addr;
        resp_kind = sdwo_pkg::RESP_BUSY;
      end
      sdwo_pkg::CMD_SEND_PROTECT:
      begin
        cmd_arg  = cmd_addr;
        has_data = 1'b1;
      end
      sdwo_pkg::CMD_STOP: resp_kind = sdwo_pkg::RESP_BUSY;
      default: known = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

/* File: sdwo_top.sv */
// Purpose: Read wait, card interrupt, completion-disable and command framing
// Assumes: Card line inputs are asynchronous and synchronised here
// Notes:   Card clock is a divided enable, driven out from a flip-flop
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Single write carries address, one block of set length, short reply.
// - Multi write carries address, runs until stop or count reached.
// - Identity programming takes stuffing argument; card accepts it only once.
// - Specific-data programming is a data command with stuffing argument.
// - Set-protect carries address; card answers with busy reply.
// - Clear-protect carries address; card answers with busy reply.
// - Send-protect carries address; protect bits return on data lines.
// - I/O special operations only while io_card_ops_enable is set.
// - Line read wait only in 1-bit or 4-bit bus width; clock-stop read wait in any width.
// - Enabled with start set before first block: idle goes to line read wait; with clock-stop selected it stays idle.
// - In read wait, data line 2 driven low after 2 card clocks.
// - On stop, 2 more cycles, then line 2 high one cycle, then busy until the next block starts.
// - No read wait entry while a block is being received.
// - Clock-stop read wait: stop clock 2 cycles after block, restart on control.
// - With I/O ops enabled, card interrupt on data lines is reported.
// - Completion signalling only when ata_command_flag is set.
// - Completion-disable sent 8 bit periods after short reply when enabled.
module sdwo_top
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        data_path_enable,
  input  wire logic        io_card_ops_enable,
  input  wire logic        read_wait_start,
  input  wire logic        read_wait_stop,
  input  wire logic        read_wait_by_clock,
  input  wire logic [1:0]  bus_width,
  input  wire logic        ata_command_flag,
  input  wire logic        cmd_end_enable,
  input  wire logic        non_interrupt_enable,
  input  wire logic        cmd_start,
  input  wire logic [5:0]  cmd_index,
  input  wire logic [31:0] cmd_addr,
  input  wire logic [15:0] block_count,
  input  wire logic        short_resp_done,
  input  wire logic        block_start,
  input  wire logic        block_done,
  input  wire logic [3:0]  data_line_in,
  output logic             card_clock,
  output logic             data_line_2_out,
  output logic             data_line_2_oe,
  output logic             ccs_disable_req,
  output logic             card_irq,
  output logic             cmd_go,
  output logic [5:0]       cmd_go_index,
  output logic [31:0]      cmd_go_arg,
  output logic [1:0]       cmd_go_resp,
  output logic             cmd_go_data,
  output logic             cmd_refused,
  output logic             busy_wait,
  output logic [2:0]       fsm_state
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sdwo_pkg::sdwo_state_e state;
  logic [7:0]  div_cnt;
  logic        card_tick;
  logic        card_run;
  logic [3:0]  cyc_cnt;
  logic [3:0]  d_meta;
  logic [3:0]  d_sync;
  logic        io_ok;
  logic        rw_width_ok;
  logic        busy_flag;
  logic        ccs_pend;
  logic [3:0]  ccs_cnt;
  logic [31:0] chk_arg;
  logic [1:0]  chk_resp;
  logic        chk_data;
  logic        chk_known;

  // ----------------------------------------------------------------
  // Card clock divider
  // ----------------------------------------------------------------
  // Tick marks each card clock falling edge; gated when clock is stopped
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      div_cnt <= 8'h00;
    else if (div_cnt == sdwo_pkg::CARD_CLK_DIV - 8'h01)
      div_cnt <= 8'h00;
    else
      div_cnt <= div_cnt + 8'h01;
  end

  assign card_tick = (div_cnt == sdwo_pkg::CARD_CLK_DIV - 8'h01) && card_run;

  // Clock high for first half of the period only while running
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      card_clock <= 1'b0;
    else
      card_clock <= card_run && (div_cnt < (sdwo_pkg::CARD_CLK_DIV >> 1));
  end

  // ----------------------------------------------------------------
  // Data line synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      d_meta <= 4'hF;
      d_sync <= 4'hF;
    end
    else
    begin
      d_meta <= data_line_in;
      d_sync <= d_meta;
    end
  end

  assign io_ok       = io_card_ops_enable;
  assign rw_width_ok = (bus_width == sdwo_pkg::WIDTH_1BIT) ||
                       (bus_width == sdwo_pkg::WIDTH_4BIT);

  // ----------------------------------------------------------------
  // Data path machine for read wait
  // ----------------------------------------------------------------
  // Counter counts card clocks; read wait never starts mid-block
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state    <= sdwo_pkg::SDWO_IDLE;
      cyc_cnt  <= 4'h0;
      card_run <= 1'b1;
    end
    else if (!data_path_enable)
    begin
      state    <= sdwo_pkg::SDWO_IDLE;
      cyc_cnt  <= 4'h0;
      card_run <= 1'b1;
    end
    else
    begin
      case (state)
        sdwo_pkg::SDWO_IDLE:
        begin
          cyc_cnt <= 4'h0;
          if (io_ok && read_wait_start && rw_width_ok && !read_wait_by_clock)
            state <= sdwo_pkg::SDWO_RW_DELAY;
          else if (block_start)
            state <= sdwo_pkg::SDWO_RECEIVE;
        end
        sdwo_pkg::SDWO_RW_DELAY:
        begin
          if (card_tick)
          begin
            if (cyc_cnt == sdwo_pkg::RW_ASSERT_CYCLES - 4'h1)
            begin
              cyc_cnt <= 4'h0;
              state   <= sdwo_pkg::SDWO_RW_HOLD;
            end
            else
              cyc_cnt <= cyc_cnt + 4'h1;
          end
        end
        sdwo_pkg::SDWO_RW_HOLD:
        begin
          cyc_cnt <= 4'h0;
          if (read_wait_stop)
            state <= sdwo_pkg::SDWO_RW_STOP;
        end
        sdwo_pkg::SDWO_RW_STOP:
        begin
          if (card_tick)
          begin
            if (cyc_cnt == sdwo_pkg::RW_STOP_CYCLES - 4'h1)
            begin
              cyc_cnt <= 4'h0;
              state   <= sdwo_pkg::SDWO_RW_HIGH;
            end
            else
              cyc_cnt <= cyc_cnt + 4'h1;
          end
        end
        sdwo_pkg::SDWO_RW_HIGH:
          if (card_tick)
            state <= sdwo_pkg::SDWO_BUSY;
        sdwo_pkg::SDWO_BUSY:
          if (block_start)
            state <= sdwo_pkg::SDWO_RECEIVE;
        sdwo_pkg::SDWO_RECEIVE:
        begin
          cyc_cnt <= 4'h0;
          // Start request is ignored until the block has ended
          if (block_done)
          begin
            if (io_ok && read_wait_start && read_wait_by_clock)
              state <= sdwo_pkg::SDWO_CK_STOP;
            else if (io_ok && read_wait_start && rw_width_ok)
              state <= sdwo_pkg::SDWO_RW_DELAY;
            else
              state <= sdwo_pkg::SDWO_BUSY;
          end
        end
        sdwo_pkg::SDWO_CK_STOP:
        begin
          // Clock stops two card clocks after the block, resumes on stop bit
          if (card_run && card_tick)
          begin
            if (cyc_cnt == sdwo_pkg::CLK_STOP_CYCLES - 4'h1)
              card_run <= 1'b0;
            else
              cyc_cnt <= cyc_cnt + 4'h1;
          end
          else if (!card_run && read_wait_stop)
          begin
            card_run <= 1'b1;
            cyc_cnt  <= 4'h0;
            state    <= sdwo_pkg::SDWO_BUSY;
          end
        end
        default: state <= sdwo_pkg::SDWO_IDLE;
      endcase
    end
  end

  // Data line 2 drive: low while holding, high for the release cycle
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      data_line_2_oe  <= 1'b0;
      data_line_2_out <= 1'b1;
      fsm_state       <= 3'h0;
    end
    else
    begin
      data_line_2_oe  <= (state == sdwo_pkg::SDWO_RW_HOLD) ||
                         (state == sdwo_pkg::SDWO_RW_STOP) ||
                         (state == sdwo_pkg::SDWO_RW_HIGH);
      data_line_2_out <= (state == sdwo_pkg::SDWO_RW_HIGH);
      fsm_state       <= state;
    end
  end

  // ----------------------------------------------------------------
  // Card interrupt detect
  // ----------------------------------------------------------------
  // Only watched outside received blocks, where line 1 carries data
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      card_irq <= 1'b0;
    else
      card_irq <= io_ok && !d_sync[1] && (state != sdwo_pkg::SDWO_RECEIVE);
  end

  // ----------------------------------------------------------------
  // Completion-disable timing
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ccs_pend        <= 1'b0;
      ccs_cnt         <= 4'h0;
      ccs_disable_req <= 1'b0;
    end
    else
    begin
      ccs_disable_req <= 1'b0;
      if (short_resp_done && ata_command_flag && !cmd_end_enable && non_interrupt_enable)
      begin
        ccs_pend <= 1'b1;
        ccs_cnt  <= 4'h0;
      end
      else if (ccs_pend && card_tick)
      begin
        if (ccs_cnt == sdwo_pkg::CCS_DIS_CYCLES - 4'h1)
        begin
          ccs_pend        <= 1'b0;
          ccs_disable_req <= 1'b1;
        end
        else
          ccs_cnt <= ccs_cnt + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command framing
  // ----------------------------------------------------------------
  sdwo_cmd_check u_check
  (
    .cmd_index   (cmd_index),
    .cmd_addr    (cmd_addr),
    .block_count (block_count),
    .cmd_arg     (chk_arg),
    .resp_kind   (chk_resp),
    .has_data    (chk_data),
    .known       (chk_known)
  );

  // Busy after a busy reply until line 0 released; data commands held off
  // Release waits for busy_wait: the synchroniser still shows pre-reply line 0
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      busy_flag <= 1'b0;
    else if (cmd_go && cmd_go_resp == sdwo_pkg::RESP_BUSY && short_resp_done)
      busy_flag <= 1'b1;
    else if (busy_wait && d_sync[0])
      busy_flag <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cmd_go       <= 1'b0;
      cmd_go_index <= 6'h00;
      cmd_go_arg   <= 32'h0000_0000;
      cmd_go_resp  <= sdwo_pkg::RESP_NONE;
      cmd_go_data  <= 1'b0;
      cmd_refused  <= 1'b0;
      busy_wait    <= 1'b0;
    end
    else
    begin
      busy_wait   <= busy_flag;
      cmd_refused <= cmd_start && (!chk_known || (chk_data && busy_flag));
      if (cmd_start && chk_known && !(chk_data && busy_flag))
      begin
        cmd_go       <= 1'b1;
        cmd_go_index <= cmd_index;
        cmd_go_arg   <= chk_arg;
        cmd_go_resp  <= chk_resp;
        cmd_go_data  <= chk_data;
      end
      else if (short_resp_done)
        cmd_go <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: sdwo_monitor.sv */
// Purpose: Port-level checks for the card host special-operations block
// Assumes: One clock domain, reset_n synchronous and active low
// Notes:   Bound onto every sdwo_top instance
`timescale 1ns/100ps
`default_nettype none
module sdwo_monitor
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        io_card_ops_enable,
  input wire logic [1:0]  bus_width,
  input wire logic        ata_command_flag,
  input wire logic        cmd_end_enable,
  input wire logic        non_interrupt_enable,
  input wire logic        cmd_start,
  input wire logic [5:0]  cmd_index,
  input wire logic        short_resp_done,
  input wire logic        data_line_2_out,
  input wire logic        data_line_2_oe,
  input wire logic        ccs_disable_req,
  input wire logic        card_irq,
  input wire logic        cmd_go,
  input wire logic [5:0]  cmd_go_index,
  input wire logic [31:0] cmd_go_arg,
  input wire logic [1:0]  cmd_go_resp,
  input wire logic        cmd_go_data,
  input wire logic        cmd_refused,
  input wire logic        busy_wait,
  input wire logic [2:0]  fsm_state
);
  // ------------------------------------------------------------
  // Command framing
  // ------------------------------------------------------------
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Argument, reply kind and data flag follow the command index
  a_stuff_arg:
    assert property (cmd_go && cmd_go_index inside {6'h1A, 6'h1B} |-> cmd_go_arg == 32'h0
      && cmd_go_data) else $error("Stuffing argument or data flag wrong");
  a_write_resp:
    assert property (cmd_go && cmd_go_index inside {6'h18, 6'h19, 6'h1E} |-> cmd_go_data
      && cmd_go_resp == sdwo_pkg::RESP_SHORT) else $error("Data command framing wrong");
  a_protect_busy:
    assert property (cmd_go && cmd_go_index inside {6'h1C, 6'h1D} |-> !cmd_go_data
      && cmd_go_resp == sdwo_pkg::RESP_BUSY) else $error("Protect command reply kind wrong");
  // A data command while the card holds busy must bounce
  a_busy_refuse:
    assert property (cmd_start && !cmd_go && cmd_index inside {6'h18, 6'h19, 6'h1A, 6'h1B,
      6'h1E} |=> !busy_wait || (cmd_refused && !cmd_go))
      else $error("Data command taken while busy");
  // ------------------------------------------------------------
  // Special operations
  // ------------------------------------------------------------
  a_irq_gate:
    assert property (card_irq |-> $past(io_card_ops_enable)) else $error("Card irq while ops off");
  a_rw_entry:
    assert property (fsm_state == sdwo_pkg::SDWO_RW_DELAY && $past(fsm_state) == 3'h0
      |-> $past(io_card_ops_enable, 2) && $past(bus_width, 2) inside {2'h0, 2'h1})
      else $error("Read wait entered without leave");
  // Drive low only after the delay state has run a while
  a_rw_drive_low:
    assert property ($rose(data_line_2_oe) |-> !data_line_2_out
      && $past(fsm_state, 3) == sdwo_pkg::SDWO_RW_DELAY) else $error("Line 2 drive too early");
  a_d2_high_once:
    assert property (data_line_2_oe && $rose(data_line_2_out) |-> data_line_2_oe[*3]
      ##[1:3] !data_line_2_oe) else $error("Line 2 high phase length wrong");
  // Eight card ticks of 4 clocks, plus sync and tick phase slack
  a_ccs_delay:
    assert property (short_resp_done && ata_command_flag && !cmd_end_enable
      && non_interrupt_enable |-> ##[24:36] ccs_disable_req) else $error("Disable pulse missing");
endmodule
bind sdwo_top sdwo_monitor mon (.clk, .reset_n, .io_card_ops_enable, .bus_width,
  .ata_command_flag, .cmd_end_enable, .non_interrupt_enable, .cmd_start, .cmd_index,
  .short_resp_done, .data_line_2_out, .data_line_2_oe, .ccs_disable_req, .card_irq, .cmd_go,
  .cmd_go_index, .cmd_go_arg, .cmd_go_resp, .cmd_go_data, .cmd_refused, .busy_wait, .fsm_state);
`default_nettype wire

/* File: sdwo_card_model.sv */
// Purpose: Behavioural card on the far side of the host block
// Assumes: Replies in the host clock domain, line 1 moves on the link clock
// Notes:   Released lines read high through their pull-ups
`timescale 1ns/100ps
`default_nettype none
module sdwo_card_model
(
  input  wire logic       clk,
  input  wire logic       lclk,
  input  wire logic       reset_n,
  input  wire logic       cmd_go,
  input  wire logic [1:0] cmd_go_resp,
  input  wire logic [7:0] resp_delay,
  input  wire logic [7:0] busy_len,
  input  wire logic       irq_req,
  input  wire logic       data_line_2_out,
  input  wire logic       data_line_2_oe,
  output logic            short_resp_done,
  output logic [3:0]      data_line_in
);
  logic [7:0] cnt;
  logic [7:0] busy_cnt;
  logic       sent;
  logic       irq_line = 1'b1;
  // ------------------------------------------------------------
  // Replies and busy
  // ------------------------------------------------------------
  // One reply per framed command; sent flag stops a second pulse
  always @(posedge clk)
  begin
    short_resp_done <= 1'b0;
    if (busy_cnt != 8'h00)
      busy_cnt <= busy_cnt - 8'h01;
    if (!reset_n || !cmd_go)
    begin
      cnt  <= 8'h00;
      sent <= 1'b0;
    end
    else if (!sent && cnt == resp_delay)
    begin
      short_resp_done <= 1'b1;
      sent            <= 1'b1;
      if (cmd_go_resp == sdwo_pkg::RESP_BUSY)
        busy_cnt <= busy_len;
    end
    else if (!sent)
      cnt <= cnt + 8'h01;
    if (!reset_n)
      busy_cnt <= 8'h00;
  end
  // Interrupt level moves only on link edges, unrelated to clk
  always @(posedge lclk)
    irq_line <= !irq_req;
  // Line 2 is shared: host drive wins, else pull-up
  assign data_line_in = {1'b1, data_line_2_oe ? data_line_2_out : 1'b1, irq_line,
                         busy_cnt == 8'h00};
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Purpose: Self-checking bench for the card host special-operations block
// Assumes: 40 MHz clock, card interrupt line moved on a 200 ns link clock
// Notes:   Command fields are predicted by a queue-based reference
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        lclk = 1'b0;
  logic        reset_n, data_path_enable, io_card_ops_enable, read_wait_start;
  logic        read_wait_stop, read_wait_by_clock, ata_command_flag, cmd_end_enable;
  logic        non_interrupt_enable, cmd_start, short_resp_done, block_start, block_done;
  logic        irq_req, card_clock, data_line_2_out, data_line_2_oe, ccs_disable_req;
  logic        card_irq, cmd_go, cmd_go_data, cmd_refused, busy_wait;
  logic [1:0]  bus_width, cmd_go_resp;
  logic [2:0]  fsm_state;
  logic [3:0]  data_line_in;
  logic [5:0]  cmd_index, cmd_go_index;
  logic [7:0]  resp_delay, busy_len;
  logic [15:0] block_count;
  logic [31:0] cmd_addr, cmd_go_arg;
  logic [41:0] exp_q[$];
  logic [5:0]  cmd_tab [10] = '{6'h17, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h0C,
                                6'h3F};
  logic [2:0]  ccs_tab [3] = '{3'h5, 3'h1, 3'h7};
  int          n_fail, tests_run, seed, i, k, n;
  // ------------------------------------------------------------
  // Clocks and instances
  // ------------------------------------------------------------
  always #12.5 clk = ~clk;
  always #100 lclk = ~lclk;
  sdwo_top DUT (.clk, .reset_n, .data_path_enable, .io_card_ops_enable, .read_wait_start,
    .read_wait_stop, .read_wait_by_clock, .bus_width, .ata_command_flag, .cmd_end_enable,
    .non_interrupt_enable, .cmd_start, .cmd_index, .cmd_addr, .block_count, .short_resp_done,
    .block_start, .block_done, .data_line_in, .card_clock, .data_line_2_out, .data_line_2_oe,
    .ccs_disable_req, .card_irq, .cmd_go, .cmd_go_index, .cmd_go_arg, .cmd_go_resp,
    .cmd_go_data, .cmd_refused, .busy_wait, .fsm_state);
  sdwo_card_model card (.clk, .lclk, .reset_n, .cmd_go, .cmd_go_resp, .resp_delay, .busy_len,
    .irq_req, .data_line_2_out, .data_line_2_oe, .short_resp_done, .data_line_in);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Sample a little after the edge so the design's updates have landed
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  // Reference: go, index, argument, reply kind, data flag
  function automatic logic [41:0] exp_of(logic [5:0] x, logic [31:0] a, logic [15:0] c);
    logic [31:0] arg;
    arg = (x == 6'h17) ? {16'h0000, c} : (x inside {6'h1A, 6'h1B, 6'h0C}) ? 32'h0 : a;
    return {1'b1, x, arg, (x inside {6'h1C, 6'h1D, 6'h0C}) ? sdwo_pkg::RESP_BUSY
            : sdwo_pkg::RESP_SHORT, x inside {6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1E}};
  endfunction
  task automatic issue(input logic [5:0] idx);
    @(posedge clk);
    cmd_start   <= 1'b1;
    cmd_index   <= idx;
    cmd_addr    <= $random(seed);
    block_count <= 16'($random(seed));
    @(posedge clk) cmd_start <= 1'b0;
    #1;
  endtask
  task automatic settle;
    for (i = 0; i < 300 && (cmd_go !== 1'b0 || busy_wait !== 1'b0); i++) tick;
    repeat (2) tick;
    for (i = 0; i < 300 && busy_wait !== 1'b0; i++) tick;
    chk("settled", {cmd_go, busy_wait}, 2'h0);
  endtask
  task automatic toggles(input int cnt, output int t);
    logic prev;
    t = 0;
    tick;
    prev = card_clock;
    repeat (cnt)
    begin
      tick;
      t += (card_clock !== prev);
      prev = card_clock;
    end
  endtask
  // ------------------------------------------------------------
  // Watchdog and main sequence
  // ------------------------------------------------------------
  initial
  begin
    #500000;
    n_fail++;
    results;
  end
  initial
  begin
    {data_path_enable, io_card_ops_enable, read_wait_start, read_wait_stop} = 4'h0;
    {read_wait_by_clock, ata_command_flag, cmd_end_enable, non_interrupt_enable} = 4'h0;
    {cmd_start, block_start, block_done, irq_req, reset_n} = 5'h00;
    {bus_width, cmd_index, cmd_addr, block_count} = 56'h0;
    {resp_delay, busy_len} = 16'h0208;
    {seed, n_fail, tests_run} = {32'd92, 64'd0};
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Every command form with prompt and slow replies, then an unknown index
    for (k = 0; k < 10; k++)
    begin
      resp_delay <= 8'($random(seed) & 32'h1F);
      busy_len   <= 8'h06 + 8'($random(seed) & 32'h1F);
      issue(cmd_tab[k]);
      exp_q.push_back(exp_of(cmd_tab[k], cmd_addr, block_count));
      if (k == 9)
        chk("refused", {cmd_refused, cmd_go}, 2'h2);
      else
        chk("frame", {cmd_go, cmd_go_index, cmd_go_arg, cmd_go_resp, cmd_go_data},
            exp_q.pop_front());
      settle;
    end
    // Data command while the card still holds line 0 low
    busy_len <= 8'h50;
    issue(6'h1C);
    for (i = 0; i < 60 && busy_wait !== 1'b1; i++) tick;
    issue(6'h18);
    chk("busy refuse", {cmd_refused, cmd_go, busy_wait}, 3'h5);
    settle;
    // Line read wait across widths, last pass with I/O ops off
    for (k = 0; k < 4; k++)
    begin
      @(posedge clk) bus_width <= (k == 3) ? 2'h1 : k[1:0];
      {io_card_ops_enable, data_path_enable, read_wait_start} <= {k != 3, 2'h3};
      for (i = 0; i < 24 && data_line_2_oe !== 1'b1; i++) tick;
      chk("d2 drive", {data_line_2_oe, data_line_2_out}, (k < 2) ? 2'h2 : 2'h0);
      @(posedge clk) read_wait_stop <= 1'b1;
      for (i = 0; i < 24 && data_line_2_out !== 1'b1; i++) tick;
      chk("d2 high", {data_line_2_oe, data_line_2_out, k > 1 || i > 5}, (k < 2) ? 3'h7 : 3'h1);
      repeat (6) tick;
      chk("d2 off", data_line_2_oe, 1'b0);
      @(posedge clk) {data_path_enable, read_wait_start, read_wait_stop} <= 3'h0;
      repeat (4) tick;
    end
    // Start request in mid-block, then clock-stop wait after the block
    @(posedge clk) {data_path_enable, io_card_ops_enable} <= 2'h3;
    @(posedge clk) block_start <= 1'b1;
    @(posedge clk) block_start <= 1'b0;
    read_wait_start <= 1'b1;
    repeat (20) tick;
    chk("no wait in block", data_line_2_oe, 1'b0);
    @(posedge clk) read_wait_by_clock <= 1'b1;
    block_done <= 1'b1;
    @(posedge clk) block_done <= 1'b0;
    repeat (14) tick;
    toggles(16, n);
    chk("clock stopped", n, 0);
    @(posedge clk) read_wait_stop <= 1'b1;
    toggles(16, n);
    chk("clock back", n > 4, 1'b1);
    @(posedge clk) {data_path_enable, read_wait_start, read_wait_stop, read_wait_by_clock} <= 4'h0;
    // Card interrupt on line 1, then gated off
    @(posedge clk) irq_req <= 1'b1;
    for (i = 0; i < 40 && card_irq !== 1'b1; i++) tick;
    chk("irq seen", card_irq, 1'b1);
    @(posedge clk) io_card_ops_enable <= 1'b0;
    repeat (3) tick;
    chk("irq gated", card_irq, 1'b0);
    @(posedge clk) irq_req <= 1'b0;
    // Completion-disable only for the one flag combination
    resp_delay <= 8'h03;
    for (k = 0; k < 3; k++)
    begin
      @(posedge clk) {ata_command_flag, cmd_end_enable, non_interrupt_enable} <= ccs_tab[k];
      issue(6'h17);
      n = 0;
      for (i = 0; i < 80; i++)
      begin
        tick;
        n += ccs_disable_req;
      end
      chk("ccs pulses", n, k == 0);
      settle;
    end
    results;
  end
endmodule
`default_nettype wire
